// File: logic/cebi_pkg.sv
// Package for the external bus interface: cycle kinds, widths and timing counts.
// Assumes a single 20 MHz core clock.
package cebi_pkg;
    localparam int          CEBI_ADDR_W       = 20;
    localparam int          CEBI_DATA_W       = 8;
    localparam int          CEBI_IO_ADDR_W    = 8;
    localparam int          CEBI_REFRESH_STROBE_N_ADDR_W  = 8;
    localparam int          CEBI_TOUT_BIT     = 18;
    localparam logic [1:0]  CEBI_T_STATES     = 2'h3;  // Clock cycles per machine cycle.
    localparam logic [1:0]  CEBI_T_LAST       = 2'h2;  // Index of the last state.
    localparam logic        CEBI_TOUT_SEL_RST = 1'b0;  // Address function after reset.

    // Kind of bus cycle requested by the core.
    typedef enum logic [2:0] {
        CEBI_CYC_FETCH = 3'h0,
        CEBI_CYC_MRD   = 3'h1,
        CEBI_CYC_MWR   = 3'h2,
        CEBI_CYC_IORD  = 3'h3,
        CEBI_CYC_IOWR  = 3'h4,
        CEBI_CYC_INTA  = 3'h5,
        CEBI_CYC_REFRESH_STROBE_N  = 3'h6
    } cebi_cyc_t;

    // Bus state, Gray-coded along idle, run, grant.
    typedef enum logic [1:0] {
        CEBI_ST_IDLE  = 2'b00,
        CEBI_ST_RUN   = 2'b01,
        CEBI_ST_GRANT = 2'b11
    } cebi_state_t;
endpackage : cebi_pkg

// File: logic/cebi_sync.sv
// Two-flop synchroniser bank for the pins sampled by the bus interface.
// Assumes the inputs come from outside the core clock domain.
`timescale 1ns/1ps
module cebi_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk_i,  // Core clock.
    input  wire logic         rstn_i,      // Synchronous reset, active low.
    input  wire logic [W-1:0] async_i,     // Raw pin levels.
    input  wire logic [W-1:0] rst_val_i,   // Idle level loaded by reset (tie to constant).
    output logic      [W-1:0] sync_o       // Synchronised levels.
);
    logic [W-1:0] meta_reg;

    // Only the second stage is read outside; reset loads the idle level.
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            meta_reg <= rst_val_i;
            sync_o   <= rst_val_i;
        end else begin
            meta_reg <= async_i;
            sync_o   <= meta_reg;
        end
    end
endmodule : cebi_sync

// File: logic/cebi_top.sv
// External bus interface of an 8-bit processor: runs memory, I/O, fetch,
// interrupt acknowledge and refresh cycles, yields the bus to an external
// master and decodes that master's accesses to the on-chip peripherals.
// Assumes the core issues one cycle request at a time, waiting for done.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Drive a 20-bit address for every bus cycle.
// - Refresh cycles put the refresh address on the bus.
// - Address bus floats during reset and bus grant.
// - External master accesses: address bus is an input and decoded.
// - Bit 18 muxed with timer output; address selected after reset (here bit 18 follows tout_sel_i, with no reset default).
// - Bidirectional data bus, driven when device supplies data.
// - Read strobe low when taking data; sensed when external master drives.
// - Write strobe low while write data is on bus; sensed when external.
// - Memory request low only with a valid memory address.
// - I/O request low while the I/O address is on the low eight lines.
// - Interrupt acknowledge asserts I/O request with opcode fetch strobe.
// - Opcode fetch asserts opcode fetch strobe with memory request.
// - Each byte of a two-byte opcode gets its own fetch strobe.
// - Refresh strobe low with memory request during refresh address.
// - Bus request: finish machine cycle, float bus, then acknowledge.
module cebi_top
    import cebi_pkg::*;
#(
    parameter logic [CEBI_ADDR_W-1:0] PERIPH_BASE = 20'h00000, // Base of on-chip peripheral window.
    parameter logic [CEBI_ADDR_W-1:0] PERIPH_MASK = 20'hfffc0  // Compare mask for the window.
) (
    input  wire logic                   core_clk_i,          // 20 MHz core clock.
    input  wire logic                   rstn_i,              // Synchronous reset, active low.
    // Core side.
    input  wire logic                   cyc_req_i,           // Start a bus cycle.
    input  wire cebi_cyc_t              cyc_kind_i,          // Kind of cycle.
    input  wire logic [CEBI_ADDR_W-1:0] cyc_addr_i,          // Cycle address.
    input  wire logic [CEBI_DATA_W-1:0] cyc_wdata_i,         // Write data.
    input  wire logic [CEBI_REFRESH_STROBE_N_ADDR_W-1:0] refresh_strobe_n_addr_i,    // Refresh row address.
    input  wire logic                   tout_sel_i,          // 1 selects timer output on bit 18.
    input  wire logic                   timer1_out_i,        // Timer channel 1 output.
    output logic                        cyc_done_o,          // Cycle finished, one pulse.
    output logic [CEBI_DATA_W-1:0]      cyc_rdata_o,         // Read data captured.
    // Address bus.
    input  wire logic [CEBI_ADDR_W-1:0] addr_bus_i,          // Pin levels.
    output logic [CEBI_ADDR_W-1:0]      addr_bus_o,          // Driven value.
    output logic [CEBI_ADDR_W-1:0]      addr_bus_oe_o,       // High while driven, per bit.
    // Data bus.
    input  wire logic [CEBI_DATA_W-1:0] data_bus_i,          // Pin levels.
    output logic [CEBI_DATA_W-1:0]      data_bus_o,          // Driven value.
    output logic                        data_bus_oe_o,       // High while driven.
    // Strobes, active low, and their active-high enable.
    input  wire logic                   rd_n_i,              // Read strobe pin level.
    output logic                        rd_n_o,              // Read strobe drive.
    input  wire logic                   wr_n_i,              // Write strobe pin level.
    output logic                        wr_n_o,              // Write strobe drive.
    output logic                        memory_request_n_o,  // Memory request drive.
    output logic                        io_request_n_o,      // I/O request drive.
    output logic                        opcode_fetch_cycle_n_o, // Fetch cycle drive.
    output logic                        refresh_strobe_n_o,  // Refresh strobe drive.
    output logic                        ctl_oe_o,            // Enable for strobe pins.
    // Bus arbitration.
    input  wire logic                   bus_grant_request_n_i, // External request, active low.
    output logic                        bus_grant_ack_n_o,   // Grant acknowledge, active low.
    // On-chip peripheral slave port.
    output logic                        per_rd_o,            // External read of peripheral, pulse.
    output logic                        per_wr_o,            // External write of peripheral, pulse.
    output logic [CEBI_ADDR_W-1:0]      per_addr_o,          // Peripheral address.
    output logic [CEBI_DATA_W-1:0]      per_wdata_o,         // Peripheral write data.
    input  wire logic [CEBI_DATA_W-1:0] per_rdata_i          // Peripheral read data.
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.
    localparam int SW = CEBI_ADDR_W + CEBI_DATA_W + 3;
    logic [SW-1:0] pin_sync;
    logic [CEBI_ADDR_W-1:0] a_s;
    logic [CEBI_DATA_W-1:0] d_s;
    logic rd_s, wr_s, breq_s;

    cebi_sync #(.W(SW)) u_sync (
        .core_clk_i (core_clk_i),
        .rstn_i     (rstn_i),
        .async_i    ({addr_bus_i, data_bus_i, rd_n_i, wr_n_i, bus_grant_request_n_i}),
        .rst_val_i  ({{(SW-3){1'b0}}, 3'h7}),
        .sync_o     (pin_sync)
    );
    assign {a_s, d_s, rd_s, wr_s, breq_s} = pin_sync;

    ////////////////////////////////////////////////////////////////////////////
    // State registers.
    cebi_state_t state_reg, state_next;
    logic [1:0]  t_reg;
    cebi_cyc_t   kind_reg;
    logic [CEBI_ADDR_W-1:0] addr_reg;
    logic [CEBI_DATA_W-1:0] wdata_reg;
    logic rd_s_d_reg, wr_s_d_reg;
    logic done_pend_reg;  // Last state just ended; read data lands one clock later.

    // Decoding of the cycle kind, shared by the strobe logic.
    function automatic logic is_mem(input cebi_cyc_t k);
        return (k == CEBI_CYC_FETCH) || (k == CEBI_CYC_MRD) || (k == CEBI_CYC_MWR) || (k == CEBI_CYC_REFRESH_STROBE_N);
    endfunction : is_mem

    function automatic logic is_rd(input cebi_cyc_t k);
        return (k == CEBI_CYC_FETCH) || (k == CEBI_CYC_MRD) || (k == CEBI_CYC_IORD);
    endfunction : is_rd

    function automatic logic is_wr(input cebi_cyc_t k);
        return (k == CEBI_CYC_MWR) || (k == CEBI_CYC_IOWR);
    endfunction : is_wr

    wire run      = (state_reg == CEBI_ST_RUN);
    wire last_t   = run && (t_reg == CEBI_T_LAST);
    // Read data reaches the core one clock after the last state, since the data pins pass two
    // flip-flops; a new cycle waits until done has been shown, so a held request is not retaken.
    wire start    = (state_reg == CEBI_ST_IDLE) && cyc_req_i && breq_s && !done_pend_reg && !cyc_done_o;
    // A pending request is honoured only between machine cycles.
    wire grant_go = (state_reg == CEBI_ST_IDLE) && !breq_s;
    wire grant_end = (state_reg == CEBI_ST_GRANT) && breq_s;

    // Next state.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            CEBI_ST_IDLE: begin
                if (grant_go) begin
                    state_next = CEBI_ST_GRANT;
                end else if (start) begin
                    state_next = CEBI_ST_RUN;
                end
            end
            CEBI_ST_RUN: begin
                if (t_reg == CEBI_T_LAST) begin
                    state_next = CEBI_ST_IDLE;
                end
            end
            CEBI_ST_GRANT: begin
                if (grant_end) begin
                    state_next = CEBI_ST_IDLE;
                end
            end
            default: state_next = CEBI_ST_IDLE;
        endcase
    end

    // Cycle context, latched at start; each fetch byte is its own cycle.
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            state_reg <= CEBI_ST_IDLE;
            t_reg     <= 2'h0;
            kind_reg  <= CEBI_CYC_MRD;
            addr_reg  <= '0;
            wdata_reg <= '0;
        end else begin
            state_reg <= state_next;
            t_reg     <= run ? ((t_reg == CEBI_T_LAST) ? 2'h0 : t_reg + 2'h1) : 2'h0;
            if (start) begin
                kind_reg  <= cyc_kind_i;
                addr_reg  <= (cyc_kind_i == CEBI_CYC_REFRESH_STROBE_N)
                           ? {{(CEBI_ADDR_W-CEBI_REFRESH_STROBE_N_ADDR_W){1'b0}}, refresh_strobe_n_addr_i}
                           : cyc_addr_i;
                wdata_reg <= cyc_wdata_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Master-cycle pin values.
    wire k_mem  = is_mem(kind_reg);
    wire k_io   = (kind_reg == CEBI_CYC_IORD) || (kind_reg == CEBI_CYC_IOWR);
    wire k_inta = (kind_reg == CEBI_CYC_INTA);
    wire k_refresh_strobe_n = (kind_reg == CEBI_CYC_REFRESH_STROBE_N);
    wire k_m1   = (kind_reg == CEBI_CYC_FETCH) || k_inta;

    // Strobes exist only inside RUN; memory and I/O kinds are exclusive.
    wire memory_request_n_nx = !(run && k_mem);
    wire io_request_n_nx = !(run && (k_io || k_inta));
    wire m1_nx   = !(run && k_m1);
    wire refresh_strobe_n_nx = !(run && k_refresh_strobe_n);
    wire rd_nx   = !(run && is_rd(kind_reg));
    wire wr_nx   = !(run && is_wr(kind_reg) && (t_reg != 2'h0));
    // Bit 18 carries the timer output when selected, on every cycle.
    wire [CEBI_ADDR_W-1:0] a_nx = tout_sel_i
        ? {addr_reg[CEBI_ADDR_W-1:CEBI_TOUT_BIT+1], timer1_out_i, addr_reg[CEBI_TOUT_BIT-1:0]}
        : addr_reg;
    wire drive_bus = (state_reg != CEBI_ST_GRANT) && !grant_go;

    ////////////////////////////////////////////////////////////////////////////
    // External master decode (bus granted).
    wire per_hit  = ((a_s & PERIPH_MASK) == PERIPH_BASE);
    wire ext_rd   = (state_reg == CEBI_ST_GRANT) && per_hit && !rd_s;
    wire ext_rd_s = ext_rd && rd_s_d_reg;
    wire ext_wr_s = (state_reg == CEBI_ST_GRANT) && per_hit && !wr_s && wr_s_d_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Output registers; reset floats everything and clears the address; bit 18 follows tout_sel_i.
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            addr_bus_o             <= '0;
            addr_bus_oe_o          <= '0;
            data_bus_o             <= '0;
            data_bus_oe_o          <= 1'b0;
            rd_n_o                 <= 1'b1;
            wr_n_o                 <= 1'b1;
            memory_request_n_o     <= 1'b1;
            io_request_n_o         <= 1'b1;
            opcode_fetch_cycle_n_o <= 1'b1;
            refresh_strobe_n_o     <= 1'b1;
            ctl_oe_o               <= 1'b0;
            bus_grant_ack_n_o      <= 1'b1;
            cyc_done_o             <= 1'b0;
            done_pend_reg          <= 1'b0;
            cyc_rdata_o            <= '0;
            per_rd_o               <= 1'b0;
            per_wr_o               <= 1'b0;
            per_addr_o             <= '0;
            per_wdata_o            <= '0;
            rd_s_d_reg             <= 1'b1;
            wr_s_d_reg             <= 1'b1;
        end else begin
            addr_bus_o             <= a_nx;
            addr_bus_oe_o          <= {CEBI_ADDR_W{drive_bus}};
            rd_n_o                 <= rd_nx;
            wr_n_o                 <= wr_nx;
            memory_request_n_o     <= memory_request_n_nx;
            io_request_n_o         <= io_request_n_nx;
            opcode_fetch_cycle_n_o <= m1_nx;
            refresh_strobe_n_o     <= refresh_strobe_n_nx;
            ctl_oe_o               <= drive_bus;
            // Acknowledge one cycle after the float, so the bus is released first.
            bus_grant_ack_n_o      <= !((state_reg == CEBI_ST_GRANT) && !grant_end);
            // Device drives data on its own writes and on external peripheral reads.
            data_bus_o             <= ext_rd ? per_rdata_i : wdata_reg;
            data_bus_oe_o          <= (run && is_wr(kind_reg)) || ext_rd;
            done_pend_reg          <= last_t;
            cyc_done_o             <= done_pend_reg;
            if (done_pend_reg && is_rd(kind_reg)) begin
                cyc_rdata_o <= d_s;
            end
            rd_s_d_reg             <= rd_s;
            wr_s_d_reg             <= wr_s;
            per_rd_o               <= ext_rd_s;
            per_wr_o               <= ext_wr_s;
            per_addr_o             <= a_s;
            per_wdata_o            <= d_s;
        end
    end
endmodule : cebi_top

// File: tb/cebi_sva.sv
// Checker for the external bus interface, bound into cebi_top.
// Assumes it sees only the top module's ports on the one core clock.
`timescale 1ns/1ps
module cebi_sva
    import cebi_pkg::*;
(
    input wire logic                   core_clk_i,             // Core clock.
    input wire logic                   rstn_i,                 // Reset, active low.
    input wire logic                   cyc_done_o,             // Cycle done pulse.
    input wire logic [CEBI_ADDR_W-1:0] addr_bus_oe_o,          // Address enable.
    input wire logic                   data_bus_oe_o,          // Data enable.
    input wire logic                   rd_n_o,                 // Read strobe.
    input wire logic                   wr_n_o,                 // Write strobe.
    input wire logic                   memory_request_n_o,     // Memory request.
    input wire logic                   io_request_n_o,         // I/O request.
    input wire logic                   opcode_fetch_cycle_n_o, // Fetch strobe.
    input wire logic                   refresh_strobe_n_o,     // Refresh strobe.
    input wire logic                   ctl_oe_o,               // Strobe enable.
    input wire logic                   bus_grant_ack_n_o,      // Grant acknowledge.
    input wire logic                   per_rd_o                // Peripheral read pulse.
);
    // One clock domain, so clock and reset are given once for all properties.
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    ////////////////////////////////////////////////////////////////////////////////
    property p_float; !bus_grant_ack_n_o |-> addr_bus_oe_o == '0 && !ctl_oe_o; endproperty
    a_float: assert property (p_float) else $error("bus driven while granted");
    property p_ack; $fell(bus_grant_ack_n_o) |-> $past(addr_bus_oe_o) == '0 && !$past(ctl_oe_o); endproperty
    a_ack: assert property (p_ack) else $error("acknowledge before bus floated");
    property p_memory_request_n; !memory_request_n_o && ctl_oe_o |-> addr_bus_oe_o == '1; endproperty
    a_memory_request_n: assert property (p_memory_request_n) else $error("memory request without address");
    property p_io_request_n; !io_request_n_o && ctl_oe_o |-> addr_bus_oe_o == '1; endproperty
    a_io_request_n: assert property (p_io_request_n) else $error("I/O request without address");
    property p_excl; ctl_oe_o |-> memory_request_n_o || io_request_n_o; endproperty
    a_excl: assert property (p_excl) else $error("memory and I/O requests together");
    property p_fetch; ctl_oe_o && !opcode_fetch_cycle_n_o && io_request_n_o |-> !memory_request_n_o; endproperty
    a_fetch: assert property (p_fetch) else $error("fetch strobe without memory request");
    property p_inta; ctl_oe_o && !opcode_fetch_cycle_n_o && !io_request_n_o |-> rd_n_o && wr_n_o; endproperty
    a_inta: assert property (p_inta) else $error("acknowledge cycle with read or write");
    property p_refresh_strobe_n; ctl_oe_o && !refresh_strobe_n_o |-> !memory_request_n_o && rd_n_o; endproperty
    a_refresh_strobe_n: assert property (p_refresh_strobe_n) else $error("refresh strobe without memory request");
    property p_wr; ctl_oe_o && !wr_n_o |-> data_bus_oe_o && $past(data_bus_oe_o); endproperty
    a_wr: assert property (p_wr) else $error("write strobe without data on bus");
    // A memory cycle holds its request three clocks and finishes as it ends.
    property p_len; $fell(memory_request_n_o) && ctl_oe_o |->
        !memory_request_n_o [*3] ##1 (memory_request_n_o && cyc_done_o); endproperty
    a_len: assert property (p_len) else $error("memory request length wrong");
    property p_per; per_rd_o |-> !bus_grant_ack_n_o; endproperty
    a_per: assert property (p_per) else $error("peripheral read while not granted");
endmodule : cebi_sva

bind cebi_top cebi_sva i_sva (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .cyc_done_o(cyc_done_o),
    .addr_bus_oe_o(addr_bus_oe_o), .data_bus_oe_o(data_bus_oe_o), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o),
    .memory_request_n_o(memory_request_n_o), .io_request_n_o(io_request_n_o), .ctl_oe_o(ctl_oe_o),
    .opcode_fetch_cycle_n_o(opcode_fetch_cycle_n_o), .refresh_strobe_n_o(refresh_strobe_n_o),
    .bus_grant_ack_n_o(bus_grant_ack_n_o), .per_rd_o(per_rd_o));

// File: tb/cebi_mem_model.sv
// Memory and I/O device model on the far side of the bus.
// Assumes one 256-byte space decoded on the low address byte.
`timescale 1ns/1ps
module cebi_mem_model
    import cebi_pkg::*;
(
    input  wire logic                   core_clk_i, // Core clock.
    input  wire logic [CEBI_ADDR_W-1:0] addr_i,     // Address pins.
    input  wire logic [CEBI_DATA_W-1:0] data_i,     // Data pins.
    input  wire logic                   sel_i,      // Strobes driven by the device.
    input  wire logic                   rd_n_i,     // Read strobe.
    input  wire logic                   wr_n_i,     // Write strobe.
    input  wire logic                   req_n_i,    // Both requests ANDed.
    output logic                        drive_o,    // Model drives the data pins.
    output logic [CEBI_DATA_W-1:0]      data_o      // Data driven.
);
    logic [CEBI_DATA_W-1:0] mem [256];
    // Preload a pattern that the bench can predict.
    initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
    // Reads are answered at once; the bus releases the moment the strobe rises.
    assign drive_o = sel_i && !rd_n_i && !req_n_i;
    assign data_o  = mem[addr_i[7:0]];
    // Writes store whatever is on the pins while the write strobe is low.
    always @(posedge core_clk_i) if (sel_i && !wr_n_i && !req_n_i) mem[addr_i[7:0]] <= data_i;
endmodule : cebi_mem_model

// File: tb/tb_top.sv
// Self-checking bench for the external bus interface.
// Assumes the memory model and checker are compiled before it.
`timescale 1ns/1ps
module tb_top import cebi_pkg::*;;
    logic core_clk_i = 0, rstn_i = 0, cyc_req_i = 0, tout_sel_i = 0, timer1_out_i = 0;
    logic brq_n = 1, ext_rd_n = 1, ext_wr_n = 1, m_drv, cyc_done_o, data_bus_oe_o, rd_n_o, wr_n_o, ctl_oe_o;
    logic memory_request_n_n, io_request_n_n, m1_n, rf_n, ack_n, per_rd_o, per_wr_o;
    cebi_cyc_t cyc_kind_i = CEBI_CYC_MRD;
    logic [19:0] cyc_addr_i = '0, ext_addr = '0, addr_bus_i, addr_bus_o, addr_bus_oe_o, per_addr_o;
    logic [7:0] cyc_wdata_i = '0, refresh_strobe_n_addr_i = '0, per_rdata_i = '0, ext_data = '0, last_d = '0;
    logic [7:0] data_bus_i, m_data, cyc_rdata_o, data_bus_o, per_wdata_o, shadow [256];
    int n_fail = 0, tests_run = 0;
    localparam logic [5:0] STB [7] = '{6'h2c, 6'h24, 6'h22, 6'h14, 6'h12, 6'h18, 6'h21};
    // Pin levels: whoever enables wins; an undriven data bus shows the inverse of its last value.
    assign addr_bus_i = (addr_bus_o & addr_bus_oe_o) | (ext_addr & ~addr_bus_oe_o);
    assign data_bus_i = data_bus_oe_o ? data_bus_o : m_drv ? m_data : !ext_wr_n ? ext_data : ~last_d;
    always @(posedge core_clk_i) last_d <= rstn_i ? data_bus_i : 8'h00;
    initial forever #25 core_clk_i = ~core_clk_i;
    cebi_top i_dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .cyc_req_i(cyc_req_i), .cyc_kind_i(cyc_kind_i),
        .cyc_addr_i(cyc_addr_i), .cyc_wdata_i(cyc_wdata_i), .refresh_strobe_n_addr_i(refresh_strobe_n_addr_i), .tout_sel_i(tout_sel_i),
        .timer1_out_i(timer1_out_i), .cyc_done_o(cyc_done_o), .cyc_rdata_o(cyc_rdata_o), .addr_bus_i(addr_bus_i),
        .addr_bus_o(addr_bus_o), .addr_bus_oe_o(addr_bus_oe_o), .data_bus_i(data_bus_i), .data_bus_o(data_bus_o),
        .data_bus_oe_o(data_bus_oe_o), .rd_n_i(ctl_oe_o ? rd_n_o : ext_rd_n), .rd_n_o(rd_n_o),
        .wr_n_i(ctl_oe_o ? wr_n_o : ext_wr_n), .wr_n_o(wr_n_o), .memory_request_n_o(memory_request_n_n),
        .io_request_n_o(io_request_n_n), .opcode_fetch_cycle_n_o(m1_n), .refresh_strobe_n_o(rf_n), .ctl_oe_o(ctl_oe_o),
        .bus_grant_request_n_i(brq_n), .bus_grant_ack_n_o(ack_n), .per_rd_o(per_rd_o), .per_wr_o(per_wr_o),
        .per_addr_o(per_addr_o), .per_wdata_o(per_wdata_o), .per_rdata_i(per_rdata_i));
    cebi_mem_model i_mem (.core_clk_i(core_clk_i), .addr_i(addr_bus_i), .data_i(data_bus_i), .sel_i(ctl_oe_o),
        .rd_n_i(rd_n_o), .wr_n_i(wr_n_o), .req_n_i(memory_request_n_n & io_request_n_n), .drive_o(m_drv), .data_o(m_data));
    ////////////////////////////////////////////////////////////////////////////////
    // Compare, count, and report a difference at once.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test;
        if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    // Expected pin address: refresh row on the low byte, timer output on bit 18 when selected.
    function automatic logic [19:0] exp_addr(input cebi_cyc_t k, input logic [19:0] a, input logic [7:0] r,
                                             input logic s, input logic t);
        logic [19:0] e;
        e = (k == CEBI_CYC_REFRESH_STROBE_N) ? {12'h000, r} : a;
        if (s) e[18] = t;
        return e;
    endfunction : exp_addr
    // One core cycle; strobes seen are gathered and the address checked while any request is low.
    task automatic run_cyc(input cebi_cyc_t k, input logic [19:0] a, input logic [7:0] d);
        logic [5:0] seen;
        logic [19:0] ea;
        logic [7:0] r;
        logic s, t;
        int i;
        seen = '0;
        r = 8'($urandom);
        s = 1'($urandom);
        t = 1'($urandom);
        ea = exp_addr(k, a, r, s, t);
        @(posedge core_clk_i);
        {cyc_req_i, cyc_kind_i, cyc_addr_i, cyc_wdata_i} <= {1'b1, k, a, d};
        {refresh_strobe_n_addr_i, tout_sel_i, timer1_out_i} <= {r, s, t};
        for (i = 0; i < 12; i++) begin
            @(posedge core_clk_i);
            #1;
            if (ctl_oe_o && !(memory_request_n_n && io_request_n_n)) begin
                seen |= ~{memory_request_n_n, io_request_n_n, m1_n, rd_n_o, wr_n_o, rf_n};
                if (!io_request_n_n) check(addr_bus_o[7:0], ea[7:0]);
                else check(addr_bus_o, ea);
            end
            if (cyc_done_o === 1'b1) break;
        end
        if (i == 12) begin
            n_fail++;
            stop_test();
        end
        cyc_req_i <= 1'b0;
        check(seen, STB[k]);
        if (k inside {CEBI_CYC_FETCH, CEBI_CYC_MRD, CEBI_CYC_IORD}) check(cyc_rdata_o, shadow[a[7:0]]);
        if (k inside {CEBI_CYC_MWR, CEBI_CYC_IOWR}) shadow[a[7:0]] = d;
    endtask : run_cyc
    // Wait, bounded, until a pulse or level shows; returns one less than the clocks it took, 12 if it never shows.
    task automatic wait_on(input int sel, output int n);
        for (n = 0; n < 12; n++) begin
            @(posedge core_clk_i);
            #1;
            if (sel == 0 ? ack_n === 1'b0 : sel == 1 ? ack_n === 1'b1 : sel == 2 ? per_rd_o === 1'b1
                : per_wr_o === 1'b1) break;
        end
        if (n == 12 && sel != 2) begin
            n_fail++;
            stop_test();
        end
    endtask : wait_on
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: reset, every cycle kind, random traffic, then a bus grant with slave accesses.
    initial begin
        int k, n;
        for (k = 0; k < 256; k++) shadow[k] = 8'(k) ^ 8'h5a;
        void'($urandom(32'ha2f5060f));
        repeat (20) @(posedge core_clk_i);
        check({addr_bus_oe_o, ctl_oe_o, data_bus_oe_o}, 22'h0);
        rstn_i <= 1'b1;
        run_cyc(CEBI_CYC_FETCH, 20'h00100, 8'h00);
        run_cyc(CEBI_CYC_FETCH, 20'h00101, 8'h00);
        for (k = 0; k < 7; k++) run_cyc(cebi_cyc_t'(k), 20'hfffff, 8'(k));
        for (k = 0; k < 80; k++) run_cyc(cebi_cyc_t'($urandom_range(6)), 20'($urandom), 8'($urandom));
        fork
            run_cyc(CEBI_CYC_MRD, 20'h00042, 8'h00);
            repeat (2) @(posedge core_clk_i) brq_n <= 1'b0;
        join
        wait_on(0, n);
        check({addr_bus_oe_o, ctl_oe_o}, 21'h0);
        @(posedge core_clk_i) {ext_addr, per_rdata_i, ext_rd_n} <= {20'h00024, 8'($urandom), 1'b0};
        wait_on(2, n);
        check(n < 12, 1'b1);
        repeat (2) @(posedge core_clk_i);
        #1 check({data_bus_oe_o, data_bus_o}, {1'b1, per_rdata_i});
        // The device holds the data bus until it sees the read strobe rise, so let it float first.
        @(posedge core_clk_i) ext_rd_n <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        {ext_addr, ext_data, ext_wr_n} <= {20'h0003f, 8'($urandom), 1'b0};
        wait_on(3, n);
        check({per_addr_o, per_wdata_o}, {20'h0003f, ext_data});
        @(posedge core_clk_i) {ext_wr_n, ext_addr, ext_rd_n} <= {1'b1, 20'h00040, 1'b0};
        wait_on(2, n);
        check(n, 12);
        @(posedge core_clk_i) {ext_rd_n, brq_n} <= 2'b11;
        wait_on(1, n);
        run_cyc(CEBI_CYC_MRD, 20'h00024, 8'h00);
        stop_test();
    end
endmodule : tb_top
